// ==== design/rtcs_consts.vh ====
`ifndef RTCS_CONSTS_VH
`define RTCS_CONSTS_VH

// Register map.
`define RTCS_ADR_SEC 6'h00
`define RTCS_ADR_MIN 6'h01
`define RTCS_ADR_HOUR 6'h02
`define RTCS_ADR_DAY 6'h03
`define RTCS_ADR_DATE 6'h04
`define RTCS_ADR_MONTH 6'h05
`define RTCS_ADR_YEAR 6'h06
`define RTCS_ADR_SQW_CTRL 6'h07
`define RTCS_ADR_RAM_LO 6'h08
`define RTCS_ADR_RAM_HI 6'h3F
`define RTCS_NUM_CLK_REGS 8

// Field positions.
`define RTCS_BIT_HALT 7
`define RTCS_BIT_H12 6
`define RTCS_BIT_PM 5
`define RTCS_BIT_SQW_LEVEL 7
`define RTCS_BIT_SQW_EN 4
`define RTCS_SQW_CTRL_MASK 8'h93

// Rate select codes.
`define RTCS_RATE_1HZ 2'h0
`define RTCS_RATE_4K 2'h1
`define RTCS_RATE_8K 2'h2
`define RTCS_RATE_32K 2'h3

// Reset values.
`define RTCS_RST_SEC 8'h80
`define RTCS_RST_OTHER 8'h00
`define RTCS_RST_PTR 6'h00

// Bus slave address.
`define RTCS_SLAVE_ADDR 7'h68

// Time base divider: 32768 time base periods per second.
`define RTCS_DIV_W 15
`define RTCS_DIV_LAST 15'h7FFF

// Write buffer.
`define RTCS_FIFO_W 14
`define RTCS_FIFO_DEPTH 16

`endif

// ==== design/rtcs_top.v ====
`timescale 1ns/1ns
`default_nettype none
`include "rtcs_consts.vh"

// Small first-in first-out buffer; no slot is lost, full uses a wrap bit.
module rtcs_fifo #(
   parameter W = 14,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_in,
   input wire rst_in,
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [W-1:0] in_data_in,
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [W-1:0] out_data_out
);
   reg [W-1:0] mem_q [0:DEPTH-1];
   reg [AW:0] wr_q;
   reg [AW:0] rd_q;
   wire empty;
   wire full;

   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready_out = !full;
   assign out_valid_out = !empty;
   assign out_data_out = mem_q[rd_q[AW-1:0]];

   // Pointers move only on a completed handshake on their own side.
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wr_q <= {(AW+1){1'b0}};
         rd_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (in_valid_in && !full)
         begin
            mem_q[wr_q[AW-1:0]] <= in_data_in;
            wr_q <= wr_q + 1'b1;
         end
         if (out_ready_in && !empty)
            rd_q <= rd_q + 1'b1;
      end
   end
endmodule // rtcs_fifo

// Summary of operation
// (R1) Clock registers sit at 00h-07h, RAM at 08h-3Fh, one flat space.
// (R2) Pointer at 3Fh wraps to 00h during multi-byte transfers.
// (R3) All time and calendar fields are BCD, one digit per nibble.
// (R4) Bit 7 of address zero halts the time base when set; here it freezes the divider, and rate 11 still passes the time base.
// (R5) Contents after power-on are undefined; host should clear the halt bit.
// (R6) Hours bit 6 set selects twelve-hour counting, clear selects twenty-four.
// (R7) Hours bit 5 is PM flag in twelve-hour mode, else tens bit.
// (R8) Each START copies time to a shadow set; reads come from it.
// (R9) Square-wave control: level bit 7, enable bit 4, rate bits 1:0.
// (R10) With enable clear the square-wave pin shows the level bit.
// (R11) With enable set the pin carries the divided time-base wave.
// (R12) Rate 00 is 1Hz, 01 4.096kHz, 10 8.192kHz, 11 32.768kHz.
// (R13) At 1Hz the time registers update on each falling square-wave edge.
// (R14) The master starts a transfer only when both lines are high.
// (R15) Data falling while clock is high is a START.
// (R16) Data rising while clock is high is a STOP ending the transfer.
// (R17) Data changes only while clock is low; one clock pulse per bit.
// (R18) Whole bytes each with a ninth acknowledge bit; no byte limit.
// (R19) The master clocks the bus no faster than 100kHz; the testbench master takes eight system clocks per bit.
// (R20) The acknowledging receiver holds data low through the ninth clock high.
// (R21) Master withholds acknowledge on the last read byte; device releases data.
// (R22) Only the master makes clock, START and STOP; device is slave.
// (R23) First byte is address 1101000 plus direction; only a match is acknowledged.
// (R24) First written byte loads the pointer; later bytes fill successive registers.
// (R25) Reads start at the current pointer, whatever it last held.
// (R26) Bytes move most significant bit first.
// (R27) Pointer increments after each data byte, wrapping from 3Fh to 00h.
module rtcs_top (
   input wire CLK_SYS_IN,
   input wire SYS_RST_IN,
   input wire SCL_IN,
   input wire SDA_IN,
   output wire SDA_DATA_OUT,
   output wire SDA_OE_N_OUT,
   input wire TB_CLK_IN,
   output wire SQW_DATA_OUT,
   output wire SQW_OE_N_OUT
);
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_RX = 5'h02;
   localparam [4:0] ST_ACK = 5'h04;
   localparam [4:0] ST_TX = 5'h08;
   localparam [4:0] ST_MACK = 5'h10;
   localparam [1:0] PH_ADDR = 2'h0;
   localparam [1:0] PH_PTR = 2'h1;
   localparam [1:0] PH_DATA = 2'h2;

   reg [7:0] regs_q [0:63];
   reg [7:0] shadow_q [0:`RTCS_NUM_CLK_REGS-1];
   reg scl_s1_q, scl_s2_q, scl_s3_q;
   reg sda_s1_q, sda_s2_q, sda_s3_q;
   reg tb_s1_q, tb_s2_q, tb_s3_q;
   reg [4:0] state_q;
   reg [3:0] cnt_q;
   reg [7:0] shift_q;
   reg [1:0] phase_q;
   reg rw_q;
   reg mack_q;
   reg [5:0] ptr_q;
   reg sda_oe_n_q;
   reg push_q;
   reg [13:0] push_data_q;
   reg [`RTCS_DIV_W-1:0] div_q;
   reg sqw_oe_n_q;
   reg [7:0] nt [0:6];
   reg [7:0] rd_byte;
   reg wave;
   reg [7:0] hr;
   reg [7:0] inc12, inc24;
   reg [7:0] mdays;
   reg c_min, c_hour, c_day, c_month, c_year;
   reg leap;
   wire scl_rise, scl_fall, bus_start, bus_stop, tb_rise, tick;
   wire fifo_in_ready, fifo_out_valid;
   wire [13:0] fifo_out_data;
   wire [7:0] ctrl;
   // Each process has its own loop index, so no variable is written by two processes.
   integer i, j, k;

   // Two-step increment of a packed BCD byte.
   function [7:0] bcd_inc;
      input [7:0] v;
      begin
         if (v[3:0] == 4'h9)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
         else
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   // SCL, SDA and the time base each pass two flops; the third flop only serves edge detection.
   always @(posedge CLK_SYS_IN)
   begin
      scl_s1_q <= SCL_IN;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= SDA_IN;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      tb_s1_q <= TB_CLK_IN;
      tb_s2_q <= tb_s1_q;
      tb_s3_q <= tb_s2_q;
   end

   assign scl_rise = scl_s2_q && !scl_s3_q;
   assign scl_fall = !scl_s2_q && scl_s3_q;
   assign bus_start = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q; // see (R15)
   assign bus_stop = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q; // see (R16)
   assign tb_rise = tb_s2_q && !tb_s3_q;
   // The halt bit freezes the divider, so no seconds tick can occur.
   assign tick = tb_rise && !regs_q[`RTCS_ADR_SEC][`RTCS_BIT_HALT] && (div_q == `RTCS_DIV_LAST); // see (R4)
   assign ctrl = regs_q[`RTCS_ADR_SQW_CTRL];

   // Clock register reads come from the snapshot so a read never tears.
   always @*
   begin
      if (ptr_q < `RTCS_ADR_RAM_LO)
         rd_byte = shadow_q[ptr_q[2:0]]; // see (R8) (R1)
      else
         rd_byte = regs_q[ptr_q]; // see (R1)
   end

   // Next calendar values, one carry chain from seconds to year.
   always @*
   begin
      for (i = 0; i < 7; i = i + 1)
         nt[i] = regs_q[i];
      hr = regs_q[`RTCS_ADR_HOUR];
      // Hour digits are incremented apart from the mode and meridian bits, which must survive.
      inc12 = bcd_inc({3'h0, hr[4:0]});
      inc24 = bcd_inc({2'h0, hr[5:0]});
      c_min = 1'b0;
      c_hour = 1'b0;
      c_day = 1'b0;
      c_month = 1'b0;
      c_year = 1'b0;
      leap = regs_q[`RTCS_ADR_YEAR][4] ? (regs_q[`RTCS_ADR_YEAR][3:0] == 4'h2 || regs_q[`RTCS_ADR_YEAR][3:0] == 4'h6)
         : (regs_q[`RTCS_ADR_YEAR][3:0] == 4'h0 || regs_q[`RTCS_ADR_YEAR][3:0] == 4'h4
         || regs_q[`RTCS_ADR_YEAR][3:0] == 4'h8);
      case (regs_q[`RTCS_ADR_MONTH])
         8'h02: mdays = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: mdays = 8'h30;
         default: mdays = 8'h31;
      endcase
      // Seconds and minutes roll at 59; the halt bit stays clear while running.
      if (regs_q[0][6:0] == 7'h59)
      begin
         nt[0] = 8'h00;
         c_min = 1'b1;
      end
      else
         nt[0] = bcd_inc({1'b0, regs_q[0][6:0]}); // see (R3)
      if (c_min)
      begin
         if (regs_q[1] == 8'h59)
         begin
            nt[1] = 8'h00;
            c_hour = 1'b1;
         end
         else
            nt[1] = bcd_inc(regs_q[1]);
      end
      if (c_hour)
      begin
         if (hr[`RTCS_BIT_H12]) // see (R6)
         begin
            // Twelve-hour: 11 to 12 flips the meridian flag, 12 to 1 does not.
            if (hr[4:0] == 5'h12)
               nt[2] = {hr[7:5], 5'h01};
            else if (hr[4:0] == 5'h11)
            begin
               nt[2] = {hr[7:6], !hr[`RTCS_BIT_PM], 5'h12}; // see (R7)
               c_day = hr[`RTCS_BIT_PM];
            end
            else
               nt[2] = {hr[7:5], inc12[4:0]}; // see (R3)
         end
         else if (hr[5:0] == 6'h23) // see (R7)
         begin
            nt[2] = {hr[7:6], 6'h00};
            c_day = 1'b1;
         end
         else
            nt[2] = {hr[7:6], inc24[5:0]}; // see (R3)
      end
      if (c_day)
      begin
         nt[3] = (regs_q[3] == 8'h07) ? 8'h01 : bcd_inc(regs_q[3]);
         if (regs_q[4] == mdays)
         begin
            nt[4] = 8'h01;
            c_month = 1'b1;
         end
         else
            nt[4] = bcd_inc(regs_q[4]);
      end
      if (c_month)
      begin
         if (regs_q[5] == 8'h12)
         begin
            nt[5] = 8'h01;
            c_year = 1'b1;
         end
         else
            nt[5] = bcd_inc(regs_q[5]);
      end
      if (c_year)
         nt[6] = (regs_q[6] == 8'h99) ? 8'h00 : bcd_inc(regs_q[6]);
   end

   // Register store: the seconds tick wins and stalls the write buffer for that cycle.
   always @(posedge CLK_SYS_IN)
   begin
      if (SYS_RST_IN)
      begin
         // Power-on contents are undefined; the clock starts halted and the host must clear it.
         regs_q[`RTCS_ADR_SEC] <= `RTCS_RST_SEC; // see (R5)
         for (j = 1; j < `RTCS_NUM_CLK_REGS; j = j + 1)
            regs_q[j] <= `RTCS_RST_OTHER;
      end
      else if (tick)
      begin
         for (j = 0; j < 7; j = j + 1)
            regs_q[j] <= nt[j]; // see (R13)
      end
      else if (fifo_out_valid)
      begin
         if (fifo_out_data[13:8] == `RTCS_ADR_SQW_CTRL)
            regs_q[fifo_out_data[13:8]] <= fifo_out_data[7:0] & `RTCS_SQW_CTRL_MASK; // see (R9)
         else
            regs_q[fifo_out_data[13:8]] <= fifo_out_data[7:0]; // see (R1)
      end
   end

   // Snapshot of the clock registers at each START.
   always @(posedge CLK_SYS_IN)
   begin
      if (bus_start)
      begin
         for (k = 0; k < `RTCS_NUM_CLK_REGS; k = k + 1)
            shadow_q[k] <= regs_q[k]; // see (R8)
      end
   end

   // Written bytes queue here, so a tick never drops a byte arriving in the same cycle.
   rtcs_fifo #(
      .W(`RTCS_FIFO_W),
      .DEPTH(`RTCS_FIFO_DEPTH),
      .AW(4)
   ) u_wbuf (
      .clk_in(CLK_SYS_IN),
      .rst_in(SYS_RST_IN),
      .in_valid_in(push_q),
      .in_ready_out(fifo_in_ready),
      .in_data_in(push_data_q),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(!tick),
      .out_data_out(fifo_out_data)
   );

   // Time base divider and square-wave pin.
   always @(posedge CLK_SYS_IN)
   begin
      if (SYS_RST_IN)
      begin
         div_q <= {`RTCS_DIV_W{1'b0}};
         sqw_oe_n_q <= 1'b1;
      end
      else
      begin
         if (tb_rise && !regs_q[`RTCS_ADR_SEC][`RTCS_BIT_HALT])
            div_q <= div_q + 1'b1; // see (R4)
         if (ctrl[`RTCS_BIT_SQW_EN])
            sqw_oe_n_q <= wave; // see (R11)
         else
            sqw_oe_n_q <= ctrl[`RTCS_BIT_SQW_LEVEL]; // see (R10)
      end
   end

   // The 1Hz wave falls exactly when the divider wraps, which is the seconds tick.
   always @*
   begin
      case (ctrl[1:0])
         `RTCS_RATE_1HZ: wave = div_q[14]; // see (R12) (R13)
         `RTCS_RATE_4K: wave = div_q[2]; // see (R12)
         `RTCS_RATE_8K: wave = div_q[1]; // see (R12)
         default: wave = tb_s2_q; // see (R12)
      endcase
   end

   // Bus slave. Output changes only follow a clock fall, so data is stable while clock is high.
   always @(posedge CLK_SYS_IN)
   begin
      if (SYS_RST_IN)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
         phase_q <= PH_ADDR;
         rw_q <= 1'b0;
         mack_q <= 1'b0;
         ptr_q <= `RTCS_RST_PTR;
         sda_oe_n_q <= 1'b1;
         push_q <= 1'b0;
         push_data_q <= 14'h0000;
      end
      else
      begin
         push_q <= 1'b0;
         if (bus_start)
         begin
            state_q <= ST_RX; // see (R15) (R14)
            cnt_q <= 4'h0;
            phase_q <= PH_ADDR;
            sda_oe_n_q <= 1'b1;
         end
         else if (bus_stop)
         begin
            state_q <= ST_IDLE; // see (R16)
            sda_oe_n_q <= 1'b1;
         end
         else
         begin
            case (state_q)
               ST_RX:
               begin
                  if (scl_rise && cnt_q != 4'h8)
                  begin
                     shift_q <= {shift_q[6:0], sda_s2_q}; // see (R26) (R17)
                     cnt_q <= cnt_q + 4'h1;
                  end
                  else if (scl_fall && cnt_q == 4'h8)
                  begin
                     state_q <= ST_ACK; // see (R18)
                     if (phase_q == PH_ADDR)
                     begin
                        if (shift_q[7:1] == `RTCS_SLAVE_ADDR) // see (R23)
                        begin
                           rw_q <= shift_q[0];
                           sda_oe_n_q <= 1'b0; // see (R20)
                           phase_q <= shift_q[0] ? PH_DATA : PH_PTR;
                        end
                        else
                           state_q <= ST_IDLE;
                     end
                     else if (phase_q == PH_PTR)
                     begin
                        ptr_q <= shift_q[5:0]; // see (R24)
                        sda_oe_n_q <= 1'b0;
                        phase_q <= PH_DATA;
                     end
                     else if (fifo_in_ready)
                     begin
                        push_q <= 1'b1; // see (R24)
                        push_data_q <= {ptr_q, shift_q};
                        ptr_q <= ptr_q + 6'h01; // see (R27) (R2)
                        sda_oe_n_q <= 1'b0;
                     end
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     cnt_q <= 4'h0;
                     if (rw_q)
                     begin
                        // Reads begin wherever the pointer was left.
                        state_q <= ST_TX; // see (R25)
                        shift_q <= rd_byte;
                        sda_oe_n_q <= rd_byte[7]; // see (R26)
                        ptr_q <= ptr_q + 6'h01; // see (R27) (R2)
                        cnt_q <= 4'h1;
                     end
                     else
                     begin
                        state_q <= ST_RX;
                        sda_oe_n_q <= 1'b1;
                     end
                  end
               end
               ST_TX:
               begin
                  if (scl_fall)
                  begin
                     if (cnt_q == 4'h8)
                     begin
                        state_q <= ST_MACK;
                        sda_oe_n_q <= 1'b1;
                     end
                     else
                     begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        sda_oe_n_q <= shift_q[6]; // see (R17)
                        cnt_q <= cnt_q + 4'h1;
                     end
                  end
               end
               ST_MACK:
               begin
                  if (scl_rise)
                     mack_q <= !sda_s2_q;
                  else if (scl_fall)
                  begin
                     if (mack_q)
                     begin
                        state_q <= ST_TX;
                        shift_q <= rd_byte;
                        sda_oe_n_q <= rd_byte[7];
                        ptr_q <= ptr_q + 6'h01; // see (R27) (R2)
                        cnt_q <= 4'h1;
                     end
                     else
                        state_q <= ST_IDLE; // see (R21)
                  end
               end
               ST_IDLE:
                  sda_oe_n_q <= 1'b1;
               default:
                  state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Both pins are open drain: the data is always low and the enable decides.
   assign SDA_DATA_OUT = 1'b0;
   assign SDA_OE_N_OUT = sda_oe_n_q;
   assign SQW_DATA_OUT = 1'b0;
   assign SQW_OE_N_OUT = sqw_oe_n_q;
endmodule // rtcs_top

`default_nettype wire

// ==== tb/rtcs_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module rtcs_chk (
   input wire logic CLK_SYS_IN,
   input wire logic SYS_RST_IN,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   input wire logic SDA_DATA_OUT,
   input wire logic SDA_OE_N_OUT,
   input wire logic TB_CLK_IN,
   input wire logic SQW_DATA_OUT,
   input wire logic SQW_OE_N_OUT
);
   logic scl_q, sda_q, act_q, quiet_q, first_q, am_q, rd_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   wire rise = SCL_IN && !scl_q;
   wire start = SCL_IN && scl_q && sda_q && !SDA_IN;
   wire stop = SCL_IN && scl_q && !sda_q && SDA_IN;
   wire nine = rise && act_q && cnt_q == 4'h8;
   // Framing is rebuilt from the raw pins, so a slip in the device's own decoder cannot hide itself.
   always @(posedge CLK_SYS_IN)
   begin
      scl_q <= SCL_IN;
      sda_q <= SDA_IN;
      if (SYS_RST_IN || stop)
      begin
         act_q <= 1'h0;
         quiet_q <= 1'h0;
         first_q <= 1'h0;
         cnt_q <= 4'h0;
      end
      else if (start)
      begin
         act_q <= 1'h1;
         quiet_q <= 1'h0;
         first_q <= 1'h1;
         cnt_q <= 4'h0;
      end
      else if (nine)
      begin
         cnt_q <= 4'h0;
         first_q <= 1'h0;
         if (first_q)
         begin
            am_q <= sh_q[7:1] == 7'h68;
            rd_q <= sh_q[0];
            quiet_q <= sh_q[7:1] != 7'h68;
         end
         else if (am_q && rd_q && SDA_IN)
            quiet_q <= 1'h1;
      end
      else if (rise && act_q)
      begin
         sh_q <= {sh_q[6:0], SDA_IN};
         cnt_q <= cnt_q + 4'h1;
      end
   end

   default clocking cb @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (SYS_RST_IN);

   a_sda_drain: assert property (SDA_DATA_OUT == 1'h0)
      else $error("serial data output is not open drain");
   a_sqw_drain: assert property (SQW_DATA_OUT == 1'h0)
      else $error("square-wave data output is not open drain");
   a_hold_high: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE_N_OUT))
      else $error("data enable moved while clock high");
   a_addr_quiet: assert property (act_q && first_q && cnt_q < 4'h8 |-> SDA_OE_N_OUT)
      else $error("device drove data during the address byte");
   a_addr_ack: assert property (nine && first_q && sh_q[7:1] == 7'h68 |-> (!SDA_OE_N_OUT)[*3])
      else $error("own address not acknowledged through clock high");
   a_foreign_nack: assert property (nine && first_q && sh_q[7:1] != 7'h68 |-> SDA_OE_N_OUT)
      else $error("foreign address acknowledged");
   a_write_ack: assert property (nine && !first_q && am_q && !rd_q |-> (!SDA_OE_N_OUT)[*3])
      else $error("written byte not acknowledged");
   a_read_release: assert property (nine && !first_q && am_q && rd_q |-> SDA_OE_N_OUT)
      else $error("device held data in the master acknowledge slot");
   a_idle_release: assert property (!act_q || quiet_q |-> SDA_OE_N_OUT)
      else $error("device drove data while idle or after a refusal");
endmodule // rtcs_chk

bind rtcs_top rtcs_chk rtcs_chk_i (.CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN), .SCL_IN(SCL_IN),
   .SDA_IN(SDA_IN), .SDA_DATA_OUT(SDA_DATA_OUT), .SDA_OE_N_OUT(SDA_OE_N_OUT), .TB_CLK_IN(TB_CLK_IN),
   .SQW_DATA_OUT(SQW_DATA_OUT), .SQW_OE_N_OUT(SQW_OE_N_OUT));
`default_nettype wire

// ==== tb/rtcs_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module rtcs_master (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_n_out
);
   // The master owns the clock and parks both lines released between frames.
   initial
   begin
      scl_out = 1'h1;
      sda_oe_n_out = 1'h1;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   // One bit slot: data moves mid-low, is sampled at the end of the high phase.
   // A slot is eight system clocks; the slave samples with its own clock, so a slower bus behaves alike.
   task automatic bit_slot(input logic v, output logic s);
      sda_oe_n_out = v;
      wait_cyc(2);
      scl_out = 1'h1;
      wait_cyc(4);
      s = sda_in;
      scl_out = 1'h0;
      wait_cyc(2);
   endtask

   task automatic start_cond();
      sda_oe_n_out = 1'h1;
      scl_out = 1'h1;
      wait_cyc(4);
      sda_oe_n_out = 1'h0;
      wait_cyc(4);
      scl_out = 1'h0;
      wait_cyc(2);
   endtask

   task automatic stop_cond();
      sda_oe_n_out = 1'h0;
      wait_cyc(2);
      scl_out = 1'h1;
      wait_cyc(4);
      sda_oe_n_out = 1'h1;
      wait_cyc(8);
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
      bit_slot(1'h1, s);
      ack = ~s;
   endtask

   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_slot(1'h1, s);
         b[i] = s;
      end
      bit_slot(last, s);
   endtask
endmodule // rtcs_master
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic tb_clk = 1'h0;
   wire logic scl, m_oe_n, d_oe_n, d_data, sqw_oe_n, sqw_data, sda, sqw_pin;
   integer seed = 32'h868d;
   integer bad_count = 0;
   integer checks_done = 0;
   integer cyc = 0;
   int rises, diff;
   logic a, prev;
   logic [5:0] ptr_m;
   logic [7:0] got;
   logic [7:0] mem [0:63];
   logic [7:0] wbuf [0:63];
   logic [7:0] foreign [0:2] = '{8'hA0, 8'hD2, 8'h50};
   logic [63:0] clk_set = 64'h00596503311299FF;

   always #20 clk = ~clk;
   always #160 tb_clk = ~tb_clk;
   // Both lines have pull-ups: a released driver lets the wire rise.
   assign sda = m_oe_n & (d_oe_n | d_data);
   assign sqw_pin = sqw_oe_n | sqw_data;

   rtcs_top rtcs_top_i (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_DATA_OUT(d_data),
      .SDA_OE_N_OUT(d_oe_n), .TB_CLK_IN(tb_clk), .SQW_DATA_OUT(sqw_data), .SQW_OE_N_OUT(sqw_oe_n));
   rtcs_master mst (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_n_out(m_oe_n));

   function automatic logic [5:0] nxt(input logic [5:0] p);
      return (p == 6'h3F) ? 6'h00 : p + 6'h01;
   endfunction

   function automatic logic [7:0] stored(input logic [5:0] p, input logic [7:0] v);
      return (p == 6'h07) ? (v & 8'h93) : v;
   endfunction

   function automatic int exp_rises(input int r);
      return (r == 3) ? 64 : (r == 2) ? 16 : (r == 1) ? 8 : 0;
   endfunction

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Pointer load then n data bytes; the model tracks pointer and contents.
   task automatic wr(input logic [5:0] p, input int n);
      mst.start_cond();
      mst.send_byte(8'hD0, a);
      chk("write address ack", 8'h01, {7'h0, a});
      mst.send_byte({2'h0, p}, a);
      ptr_m = p;
      for (int i = 0; i < n; i++)
      begin
         mst.send_byte(wbuf[i], a);
         chk("data ack", 8'h01, {7'h0, a});
         mem[ptr_m] = stored(ptr_m, wbuf[i]);
         ptr_m = nxt(ptr_m);
      end
      mst.stop_cond();
   endtask

   task automatic rd(input int n);
      mst.start_cond();
      mst.send_byte(8'hD1, a);
      chk("read address ack", 8'h01, {7'h0, a});
      for (int i = 0; i < n; i++)
      begin
         mst.recv_byte(i == n - 1, got);
         chk("read byte", mem[ptr_m], got);
         ptr_m = nxt(ptr_m);
      end
      mst.stop_cond();
   endtask

   // Hang guard: the whole sequence needs well under half this budget.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         bad_count++;
         report_and_stop();
      end
   end

   initial
   begin
      for (int i = 0; i < 8; i++) mem[i] = (i == 0) ? 8'h80 : 8'h00;
      ptr_m = 6'h00;
      repeat (6) @(posedge clk);
      #1 rst = 1'h0;
      repeat (4) @(posedge clk);
      #1 chk("sqw level after reset", 8'h00, {7'h0, sqw_pin});
      rd(8);
      // Foreign addresses, two of them one-bit misses of the own address, one in the top bit.
      for (int k = 0; k < 3; k++)
      begin
         mst.start_cond();
         mst.send_byte(foreign[k], a);
         chk("foreign address nack", 8'h00, {7'h0, a});
         mst.stop_cond();
      end
      // Fill all of RAM and run on past the top; the wrapped byte clears the halt bit.
      for (int i = 0; i < 57; i++) wbuf[i] = 8'($random(seed));
      wbuf[56] = 8'h00;
      wr(6'h08, 57);
      for (int i = 0; i < 8; i++) wbuf[i] = clk_set[63 - 8 * i -: 8];
      wr(6'h00, 8);
      wr(6'h00, 0);
      rd(8);
      wr(6'h3E, 0);
      rd(4);
      rd(1);
      wr(6'h08, 0);
      rd(56);
      // Disabled output follows the level bit both ways.
      for (int v = 0; v < 2; v++)
      begin
         wbuf[0] = v ? 8'h80 : 8'h00;
         wr(6'h07, 1);
         repeat (4) @(posedge clk);
         #1 chk("sqw idle level", 8'(v), {7'h0, sqw_pin});
      end
      // Every rate code, counted over 64 time-base periods with one edge of slack.
      for (int r = 0; r < 4; r++)
      begin
         wbuf[0] = 8'h10 | 8'(r);
         wr(6'h07, 1);
         repeat (16) @(posedge clk);
         prev = sqw_pin;
         rises = 0;
         repeat (512)
         begin
            @(posedge clk);
            #1;
            if (sqw_pin && !prev) rises++;
            prev = sqw_pin;
         end
         diff = rises - exp_rises(r);
         chk("sqw rate in range", 8'h01, {7'h0, diff >= -1 && diff <= 1});
      end
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
